// ===== core/aoc_map.vh
`ifndef AOC_MAP_VH
`define AOC_MAP_VH
// register indices, as carried in the command byte
`define AOC_ADDR_STATUS   7'h01
`define AOC_ADDR_IRQMASK  7'h02
`define AOC_ADDR_CONFIG   7'h03
`define AOC_ADDR_CONTROL  7'h04
`define AOC_ADDR_CHMODE   7'h05
`define AOC_ADDR_DATA0    7'h09
// configuration field positions
`define AOC_CFG_LATCH_HI  15
`define AOC_CFG_LATCH_LO  12
`define AOC_CFG_EDGE_HI   11
`define AOC_CFG_EDGE_LO   10
`define AOC_CFG_RSVD      9
`define AOC_CFG_REFSEL    8
`define AOC_CFG_TMO_HI    7
`define AOC_CFG_TMO_LO    4
`define AOC_CFG_TMOACT    3
`define AOC_CFG_TMOEN     2
`define AOC_CFG_OCRESP    1
`define AOC_CFG_CRCEN     0
`define AOC_CFG_RESET     16'h0001
// pin idle levels as seen by the synchronisers: load and select high, the rest low
`define AOC_SYNC_IDLE     8'h0c
// status, mask, control, channel-mode and data field positions
`define AOC_ST_OC_LO      8
`define AOC_ST_TMO        2
`define AOC_ST_CRC        0
`define AOC_MASK_TMO      2
`define AOC_CTL_LOAD_LO   12
`define AOC_PWR_LO        8
`define AOC_DATA_LO       4
// frame layout
`define AOC_FRAME_PLAIN   6'd24
`define AOC_FRAME_CRC     6'd32
`define AOC_CMD_READ      0
`define AOC_CRC_POLY      8'h07
// timing
`define AOC_CLK_MHZ       200
`define AOC_TMO_STEP_MS   100
`define AOC_RETRY_US      8000
`define AOC_RETRY_ON_US   400
`endif

// ===== core/aoc_oc_retry.v
`timescale 1ns/1ps
`include "aoc_map.vh"
module aoc_oc_retry #(
    parameter RETRY_CYC = `AOC_RETRY_US * `AOC_CLK_MHZ,
    parameter ON_CYC    = `AOC_RETRY_ON_US * `AOC_CLK_MHZ
) (
    input  wire clk,
    input  wire reset_n,
    input  wire softClr,
    input  wire autoMode,
    input  wire chanPower,
    input  wire fault,
    output reg  ampOn_r,
    output reg  trip_r
);
    localparam [2:0] ST_RUN  = 3'b001;
    localparam [2:0] ST_WAIT = 3'b010;
    localparam [2:0] ST_TRY  = 3'b100;

    reg [2:0]  state_r;
    reg [2:0]  state_nxt;
    reg [20:0] cnt_r;
    reg [20:0] cnt_nxt;
    reg        trip_nxt;

    ////////////////////////////////////////////////////////////////
    // shutdown and retry sequencing
    always @* begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + 21'h000001;
        trip_nxt  = 1'b0;
        case (state_r)
            ST_RUN: begin
                cnt_nxt = 21'h000000;
                if (chanPower && fault) begin
                    trip_nxt = 1'b1;
                    if (autoMode) begin
                        state_nxt = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (!chanPower || !autoMode) begin
                    state_nxt = ST_RUN;
                end else if (cnt_r == RETRY_CYC[20:0] - 21'h000001) begin
                    state_nxt = ST_TRY;
                    cnt_nxt   = 21'h000000;
                end
            end
            ST_TRY: begin
                if (!chanPower || !autoMode) begin
                    state_nxt = ST_RUN;
                end else if (cnt_r == ON_CYC[20:0] - 21'h000001) begin
                    // fault gone at end of window: stay powered
                    state_nxt = fault ? ST_WAIT : ST_RUN;
                    cnt_nxt   = 21'h000000;
                end
            end
            default: begin
                state_nxt = ST_RUN;
                cnt_nxt   = 21'h000000;
            end
        endcase
        if (softClr) begin
            state_nxt = ST_RUN;
            cnt_nxt   = 21'h000000;
            trip_nxt  = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // amplifier drops in the same edge that the fault is seen in ST_RUN; ST_TRY keeps it on to the end of the window
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_RUN;
            cnt_r   <= 21'h000000;
            trip_r  <= 1'b0;
            ampOn_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            trip_r  <= trip_nxt;
            ampOn_r <= (state_nxt == ST_TRY) ||
                       (state_nxt == ST_RUN && chanPower && !trip_nxt && !softClr);
        end
    end
endmodule

// ===== core/aoc_config_reg.v
`timescale 1ns/1ps
`include "aoc_map.vh"
module aoc_config_reg #(
    parameter TMO_STEP_CYC = `AOC_TMO_STEP_MS * 1000 * `AOC_CLK_MHZ,
    parameter RETRY_CYC    = `AOC_RETRY_US * `AOC_CLK_MHZ,
    parameter ON_CYC       = `AOC_RETRY_ON_US * `AOC_CLK_MHZ
) (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        spiSclk,
    input  wire        spiCsN,
    input  wire        spiMosi,
    output reg         spiMiso_r,
    output reg         spiMisoOe_r,
    input  wire        extLoadN,
    input  wire [3:0]  ocDetect,
    output wire [3:0]  ampEnable,
    output reg  [47:0] dacCode_r,
    output reg  [15:0] config_r,
    output reg  [3:0]  chanPower_r,
    output reg  [3:0]  ocFlag_r,
    output reg         timeoutFlag_r
);
    // crc-8, msb first, zero start; shared by check and generate
    function [7:0] crc8;
        input [23:0] d;
        integer i;
        reg [7:0] c;
        begin
            c = 8'h00;
            for (i = 23; i >= 0; i = i - 1) begin
                c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `AOC_CRC_POLY : 8'h00);
            end
            crc8 = c;
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // two-flop synchronisers; stage b feeds logic, c finds edges
    reg [7:0] syncA_r;
    reg [7:0] syncB_r;
    reg [2:0] syncC_r;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // idle levels, so no false select, load or fault edge follows reset
            syncA_r <= `AOC_SYNC_IDLE;
            syncB_r <= `AOC_SYNC_IDLE;
            syncC_r <= 3'h6;
        end else begin
            syncA_r <= {ocDetect, extLoadN, spiCsN, spiMosi, spiSclk};
            syncB_r <= syncA_r;
            syncC_r <= {syncB_r[3], syncB_r[2], syncB_r[0]};
        end
    end
    wire [3:0] faultS  = syncB_r[7:4];
    wire       mosiS   = syncB_r[1];
    wire       sclkRise = syncB_r[0] & ~syncC_r[0];
    wire       sclkFall = ~syncB_r[0] & syncC_r[0];
    wire       csActive = ~syncB_r[2];
    wire       csRise   = syncB_r[2] & ~syncC_r[1];
    wire       pinLoad  = ~syncB_r[3] & syncC_r[2];  // falling edge of load pin

    ////////////////////////////////////////////////////////////////
    // frame receiver; shifting stops at the frame length
    wire       crcOn    = config_r[`AOC_CFG_CRCEN];
    wire [5:0] frameLen = crcOn ? `AOC_FRAME_CRC : `AOC_FRAME_PLAIN;
    reg  [5:0]  bitCnt_r;
    reg  [31:0] rxShift_r;
    reg  [31:0] txShift_r;
    wire [7:0]  cmdEarly = {rxShift_r[6:0], mosiS};
    wire [7:0]  cmdByte  = crcOn ? rxShift_r[31:24] : rxShift_r[23:16];
    wire [15:0] wData    = crcOn ? rxShift_r[23:8] : rxShift_r[15:0];
    wire        crcOk    = !crcOn || (crc8(rxShift_r[31:8]) == rxShift_r[7:0]);
    wire        frameOk  = csRise && (bitCnt_r >= frameLen);
    wire        doWrite  = frameOk && crcOk && !cmdByte[`AOC_CMD_READ];
    wire [6:0]  wAddr    = cmdByte[7:1];
    wire        readLoad = sclkRise && csActive && bitCnt_r == 6'd7 &&
                           cmdEarly[`AOC_CMD_READ];

    // read data selection
    reg [15:0] rData;
    reg        irqMask_r;
    reg        crcErr_r;
    reg [11:0] dataReg_r [0:3];
    always @* begin
        rData = 16'h0000;
        case (cmdEarly[7:1])
            `AOC_ADDR_STATUS:  begin
                rData[`AOC_ST_OC_LO+3:`AOC_ST_OC_LO] = ocFlag_r;
                rData[`AOC_ST_TMO] = timeoutFlag_r;
                rData[`AOC_ST_CRC] = crcErr_r;
            end
            `AOC_ADDR_IRQMASK: rData[`AOC_MASK_TMO] = irqMask_r;
            `AOC_ADDR_CONFIG:  rData = config_r;
            `AOC_ADDR_CHMODE:  rData[`AOC_PWR_LO+3:`AOC_PWR_LO] = chanPower_r;
            `AOC_ADDR_DATA0:   rData = {dataReg_r[0], 4'h0};
            `AOC_ADDR_DATA0 + 7'h01: rData = {dataReg_r[1], 4'h0};
            `AOC_ADDR_DATA0 + 7'h02: rData = {dataReg_r[2], 4'h0};
            `AOC_ADDR_DATA0 + 7'h03: rData = {dataReg_r[3], 4'h0};
            default:           rData = 16'h0000;
        endcase
    end

    // shift in on rising, out on falling clock edges
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bitCnt_r    <= 6'd0;
            rxShift_r   <= 32'h00000000;
            txShift_r   <= 32'h00000000;
            spiMiso_r   <= 1'b0;
            spiMisoOe_r <= 1'b0;
        end else begin
            spiMisoOe_r <= csActive;
            if (!csActive) begin
                bitCnt_r  <= 6'd0;
                txShift_r <= 32'h00000000;
                spiMiso_r <= 1'b0;
            end else if (sclkRise) begin
                if (bitCnt_r < frameLen) begin
                    rxShift_r <= {rxShift_r[30:0], mosiS};
                    bitCnt_r  <= bitCnt_r + 6'd1;
                end
                if (readLoad) begin
                    txShift_r <= {rData, crc8({cmdEarly, rData}), 8'h00};
                end
            end else if (sclkFall && bitCnt_r >= 6'd8) begin
                spiMiso_r <= txShift_r[31];
                txShift_r <= {txShift_r[30:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // inactivity timer, in 100 ms steps
    reg  [24:0] stepCnt_r;
    reg  [4:0]  steps_r;
    wire        cfgWrite   = doWrite && wAddr == `AOC_ADDR_CONFIG;
    wire        stepTick   = stepCnt_r == TMO_STEP_CYC[24:0] - 25'h0000001;
    wire [4:0]  stepLimit  = {1'b0, config_r[`AOC_CFG_TMO_HI:`AOC_CFG_TMO_LO]} + 5'd1;
    wire        tmoExpire  = config_r[`AOC_CFG_TMOEN] && stepTick &&
                             steps_r == stepLimit - 5'd1;
    wire        devClr     = tmoExpire && config_r[`AOC_CFG_TMOACT];
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stepCnt_r <= 25'h0000000;
            steps_r   <= 5'd0;
        end else if (frameOk || cfgWrite || !config_r[`AOC_CFG_TMOEN] || tmoExpire) begin
            stepCnt_r <= 25'h0000000;
            steps_r   <= 5'd0;
        end else if (stepTick) begin
            stepCnt_r <= 25'h0000000;
            steps_r   <= steps_r + 5'd1;
        end else begin
            stepCnt_r <= stepCnt_r + 25'h0000001;
        end
    end

    ////////////////////////////////////////////////////////////////
    // overcurrent handlers, one per channel
    wire [3:0] trip;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gOc
            aoc_oc_retry #(
                .RETRY_CYC (RETRY_CYC),
                .ON_CYC    (ON_CYC)
            ) uRetry (
                .clk       (clk),
                .reset_n   (reset_n),
                .softClr   (devClr),
                .autoMode  (!config_r[`AOC_CFG_OCRESP]),
                .chanPower (chanPower_r[g]),
                .fault     (faultS[g]),
                .ampOn_r   (ampEnable[g]),
                .trip_r    (trip[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // flags: a set wins over a status-read clear; the device clear wins over an oc or crc set
    wire statusRead = readLoad && cmdEarly[7:1] == `AOC_ADDR_STATUS;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timeoutFlag_r <= 1'b0;
            ocFlag_r      <= 4'h0;
            crcErr_r      <= 1'b0;
        end else begin
            timeoutFlag_r <= tmoExpire | (timeoutFlag_r & ~statusRead);
            ocFlag_r      <= devClr ? 4'h0 : trip | (ocFlag_r & {4{~statusRead}});
            crcErr_r      <= devClr ? 1'b0 :
                             (frameOk & ~crcOk) | (crcErr_r & ~statusRead);
        end
    end

    ////////////////////////////////////////////////////////////////
    // register writes and the time-out device clear
    integer ch;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            config_r    <= `AOC_CFG_RESET;
            irqMask_r   <= 1'b0;
            chanPower_r <= 4'h0;
            dacCode_r   <= 48'h000000000000;
            for (ch = 0; ch < 4; ch = ch + 1) begin
                dataReg_r[ch] <= 12'h000;
            end
        end else if (devClr) begin
            // mask, crc enable and reference survive the clear
            config_r    <= config_r & ((16'h0001 << `AOC_CFG_CRCEN) |
                                       (16'h0001 << `AOC_CFG_REFSEL));
            chanPower_r <= 4'h0;
            dacCode_r   <= 48'h000000000000;
            for (ch = 0; ch < 4; ch = ch + 1) begin
                dataReg_r[ch] <= 12'h000;
            end
        end else begin
            if (cfgWrite) begin
                config_r <= wData & ~(16'h0001 << `AOC_CFG_RSVD);
            end
            if (doWrite && wAddr == `AOC_ADDR_IRQMASK) begin
                irqMask_r <= wData[`AOC_MASK_TMO];
            end
            if (doWrite && wAddr == `AOC_ADDR_CHMODE) begin
                chanPower_r <= wData[`AOC_PWR_LO+3:`AOC_PWR_LO];
            end
            for (ch = 0; ch < 4; ch = ch + 1) begin
                // host mode trip drops the power bit, overriding a write
                if (trip[ch] && config_r[`AOC_CFG_OCRESP]) begin
                    chanPower_r[ch] <= 1'b0;
                end
                if (doWrite && wAddr == `AOC_ADDR_DATA0 + ch[6:0]) begin
                    dataReg_r[ch] <= wData[15:`AOC_DATA_LO];
                    if (config_r[`AOC_CFG_LATCH_LO + ch]) begin
                        dacCode_r[ch*12 +: 12] <= wData[15:`AOC_DATA_LO];
                    end
                end
                // load strobes exist only for the frame that carries them
                if (!config_r[`AOC_CFG_LATCH_LO + ch] &&
                    (pinLoad || (doWrite && wAddr == `AOC_ADDR_CONTROL &&
                                 wData[`AOC_CTL_LOAD_LO + ch]))) begin
                    dacCode_r[ch*12 +: 12] <= dataReg_r[ch];
                end
            end
        end
    end
endmodule

// ===== verification/aoc_config_reg_assertions.sv
`timescale 1ns/1ps
module aoc_config_reg_checker #(
    parameter TMO_STEP_CYC = 200,
    parameter RETRY_CYC    = 64,
    parameter ON_CYC       = 16
) (
    input wire        clk,
    input wire        reset_n,
    input wire        spiCsN,
    input wire [3:0]  ocDetect,
    input wire [3:0]  ampEnable,
    input wire [47:0] dacCode_r,
    input wire [15:0] config_r,
    input wire [3:0]  chanPower_r,
    input wire [3:0]  ocFlag_r,
    input wire        timeoutFlag_r
);
    int   quietCnt_r; // cycles since the select pin last rose
    int   offCnt_r;   // cycles amplifier 0 has been off
    logic csPrev_r;

    // counted from the pin rise, so the commit latency shows up as slack
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            quietCnt_r <= 0;
            offCnt_r   <= 0;
            csPrev_r   <= 1'b1;
        end else begin
            quietCnt_r <= (spiCsN && !csPrev_r) ? 0 : quietCnt_r + 1;
            offCnt_r   <= ampEnable[0] ? 0 : offCnt_r + 1;
            csPrev_r   <= spiCsN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_reset_value: assert property ($rose(reset_n) |-> config_r == 16'h0001)
        else $error("config reset value wrong");
    a_rsvd_zero: assert property (config_r[9] == 1'b0)
        else $error("reserved bit set");
    a_tmo_needs_en: assert property ($rose(timeoutFlag_r) |-> $past(config_r[2]))
        else $error("time-out while disabled");
    a_tmo_flag_only: assert property ($rose(timeoutFlag_r) && !$past(config_r[3])
        |-> $stable(config_r) && $stable(chanPower_r)) else $error("flag-only expiry disturbed state");
    a_tmo_spares: assert property ($rose(timeoutFlag_r) && $past(config_r[3])
        |-> ##[0:1] ((config_r & 16'hfefe) == 16'h0000 && chanPower_r == 4'h0
        && dacCode_r == 48'h0)) else $error("expiry reset incomplete");
    a_tmo_period: assert property ($rose(timeoutFlag_r)
        |-> quietCnt_r >= ($past(config_r[7:4]) + 1) * TMO_STEP_CYC
        && quietCnt_r <= ($past(config_r[7:4]) + 1) * TMO_STEP_CYC + 10)
        else $error("time-out period wrong");
    a_host_trip: assert property (config_r[1] && $rose(ocFlag_r[0])
        |-> ##[0:1] (!chanPower_r[0] && !ampEnable[0])) else $error("host trip wrong");
    a_retry_gap: assert property (!config_r[1] && ocFlag_r[0] && $rose(ampEnable[0])
        |-> offCnt_r >= RETRY_CYC - 1 && offCnt_r <= RETRY_CYC + 2) else $error("retry gap wrong");
    a_retry_window: assert property (!config_r[1] && ocFlag_r[0] && $rose(ampEnable[0])
        && ocDetect[0] |-> ampEnable[0][*8]) else $error("retry window short");
    a_dac_quiet: assert property ($changed(dacCode_r) |-> spiCsN)
        else $error("dac changed inside a frame");
endmodule

bind aoc_config_reg aoc_config_reg_checker #(
    .TMO_STEP_CYC(TMO_STEP_CYC), .RETRY_CYC(RETRY_CYC), .ON_CYC(ON_CYC)) u_checker (
    .clk(clk), .reset_n(reset_n), .spiCsN(spiCsN), .ocDetect(ocDetect),
    .ampEnable(ampEnable), .dacCode_r(dacCode_r), .config_r(config_r),
    .chanPower_r(chanPower_r), .ocFlag_r(ocFlag_r), .timeoutFlag_r(timeoutFlag_r));

// ===== verification/aoc_spi_host.sv
`timescale 1ns/1ps
module aoc_spi_host (
    output logic spiSclk,
    output logic spiCsN,
    output logic spiMosi,
    input  wire  spiMiso
);
    logic crcOn    = 1'b1; // bench tracks the frame length in use
    logic badCrc   = 1'b0; // only the crc scenario corrupts the check byte
    logic rxCrcErr = 1'b0;
    initial begin
        spiSclk = 1'b0;
        spiCsN  = 1'b1;
        spiMosi = 1'b0;
    end

    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction

    // mode 0, msb first, 48 ns link clock that stands still between frames
    task automatic xfer(input logic [6:0] addr, input logic rd, input logic [15:0] wdata,
                        output logic [15:0] rdata);
        logic [31:0] tx;
        logic [31:0] rx;
        int          n;
        n = crcOn ? 32 : 24;
        tx = crcOn ? {addr, rd, wdata, crc8({addr, rd, wdata}) ^ {7'h00, badCrc}}
                   : {8'h00, addr, rd, wdata};
        rx = 32'h0;
        spiCsN = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            spiMosi = tx[i];
            #24;
            spiSclk = 1'b1;
            rx[i] = spiMiso;
            #24;
            spiSclk = 1'b0;
        end
        #24;
        spiCsN = 1'b1;
        spiMosi = ~spiMosi; // released line shows no stale bit
        rdata = rx[n-9 -: 16];
        if (rd && crcOn && rx[7:0] !== crc8({addr, rd, rx[23:8]})) rxCrcErr = 1'b1;
        #48; // select stays high well past the commit
    endtask
endmodule

// ===== verification/aoc_config_reg_tb_top.sv
`timescale 1ns/1ps
module aoc_config_reg_tb_top;
    logic        clk;
    logic        reset_n;
    logic        extLoadN;
    logic [3:0]  ocDetect;
    wire         sclk;
    wire         csN;
    wire         mosi;
    wire         miso;
    wire         misoOe;
    wire  [3:0]  amp;
    wire  [47:0] dac;
    wire  [15:0] cfg;
    wire  [3:0]  pwr;
    wire  [3:0]  ocf;
    wire         tmo;
    int          numErrors = 0;
    int          checkCount = 0;

    // step kept above one frame length so expiry never lands mid-frame
    aoc_config_reg #(.TMO_STEP_CYC(400), .RETRY_CYC(64), .ON_CYC(16)) dut (
        .clk(clk), .reset_n(reset_n), .spiSclk(sclk), .spiCsN(csN), .spiMosi(mosi),
        .spiMiso_r(miso), .spiMisoOe_r(misoOe), .extLoadN(extLoadN), .ocDetect(ocDetect),
        .ampEnable(amp), .dacCode_r(dac), .config_r(cfg), .chanPower_r(pwr),
        .ocFlag_r(ocf), .timeoutFlag_r(tmo));
    // an undriven line shows the inverse, so a late enable spoils the read data
    aoc_spi_host host (.spiSclk(sclk), .spiCsN(csN), .spiMosi(mosi),
                       .spiMiso(misoOe ? miso : ~miso));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // whole run is about 85 us, well under the 400 us limit
    initial begin
        #400000;
        numErrors++;
        results;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        checkCount++;
        if (got !== exp) begin
            numErrors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results;
        if (numErrors == 0 && checkCount > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        // 1.5 ns offset keeps every 24 ns link step off the rising edge
        #1.5;
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] v);
        logic [15:0] d;
        host.xfer(a, 1'b0, v, d);
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
        logic [15:0] d;
        host.xfer(a, 1'b1, 16'h0000, d);
        check(d, e);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check(cfg, 16'h0001);
        check(misoOe, 1'b0);
        rdchk(7'h03, 16'h0001);
        rdchk(7'h7f, 16'h0000);
    endtask
    task automatic t_fields;
        for (int e = 0; e < 4; e++) begin
            wr(7'h03, {4'h0, e[1:0], 2'b11, 8'h01});
            rdchk(7'h03, {4'h0, e[1:0], 2'b01, 8'h01});
        end
        wr(7'h03, 16'hfef1);
        rdchk(7'h03, 16'hfcf1);
        wr(7'h03, 16'h0001);
        rdchk(7'h03, 16'h0001);
    endtask
    task automatic t_latch;
        wr(7'h09, 16'habc0);
        check(dac[11:0], 12'h000);
        wr(7'h04, 16'h1000);
        check(dac[11:0], 12'habc);
        rdchk(7'h04, 16'h0000);
        wr(7'h09, 16'h1230);
        @(posedge clk) extLoadN <= 1'b0;
        tick(6);
        @(posedge clk) extLoadN <= 1'b1;
        tick(2);
        check(dac[11:0], 12'h123);
        wr(7'h03, 16'h2001);
        wr(7'h0a, 16'h4560);
        check(dac[23:12], 12'h456);
    endtask
    task automatic t_crc;
        host.badCrc = 1'b1;
        wr(7'h03, 16'h0101);
        host.badCrc = 1'b0;
        rdchk(7'h03, 16'h2001);
        rdchk(7'h01, 16'h0001);
        wr(7'h03, 16'h0000);
        host.crcOn = 1'b0;
        rdchk(7'h03, 16'h0000);
        wr(7'h03, 16'h0001);
        host.crcOn = 1'b1;
        rdchk(7'h03, 16'h0001);
        check(host.rxCrcErr, 1'b0);
    endtask
    task automatic t_timeout;
        for (int c = 0; c < 2; c++) begin
            wr(7'h03, {8'h00, c[3:0], 4'h5});
            tick((c + 1) * 400 - 30);
            check(tmo, 1'b0);
            tick(50);
            check({tmo, cfg}, {1'b1, 8'h00, c[3:0], 4'h5});
            rdchk(7'h01, 16'h0004);
            check(tmo, 1'b0);
        end
        wr(7'h03, 16'h0001);
        tick(1000);
        check(tmo, 1'b0);
    endtask
    task automatic t_tmo_reset;
        wr(7'h02, 16'h0004);
        wr(7'h05, 16'h0f00);
        wr(7'h03, 16'hfd0f);
        tick(440);
        check({tmo, cfg, pwr}, {1'b1, 16'h0101, 4'h0});
        check(dac, 48'h0);
        rdchk(7'h02, 16'h0004);
        rdchk(7'h01, 16'h0004);
    endtask
    task automatic t_oc_host;
        wr(7'h03, 16'h0003);
        wr(7'h05, 16'h0100);
        @(posedge clk) ocDetect <= 4'h1;
        tick(8);
        check({pwr[0], amp[0], ocf[0]}, 3'b001);
        @(posedge clk) ocDetect <= 4'h0;
        tick(200);
        check(amp[0], 1'b0);
        wr(7'h05, 16'h0100);
        check({pwr[0], amp[0]}, 2'b11);
    endtask
    task automatic t_oc_auto;
        rdchk(7'h01, 16'h0100);
        wr(7'h03, 16'h0001);
        @(posedge clk) ocDetect <= 4'h1;
        tick(8);
        check({amp[0], ocf[0]}, 2'b01);
        tick(64);
        check(amp[0], 1'b1);
        tick(16);
        check(amp[0], 1'b0);
        @(posedge clk) ocDetect <= 4'h0;
        tick(300);
        check({amp[0], pwr[0]}, 2'b11);
    endtask

    // main sequence
    initial begin
        reset_n  = 1'b0;
        extLoadN = 1'b1;
        ocDetect = 4'h0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        tick(6);
        t_reset;
        t_fields;
        t_latch;
        t_crc;
        t_timeout;
        t_tmo_reset;
        t_oc_host;
        t_oc_auto;
        results;
    end
endmodule
